// ### verilog/gpe_regs.svh
/*
 * Register map, reset values and bus constants of the 8-bit GPIO port.
 * Assumes byte addressing on a 32-bit Avalon-MM slave, one word each.
 */
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define GPE_OFF_DATA   6'h00
`define GPE_OFF_OE     6'h04
`define GPE_OFF_FUNC1  6'h08
`define GPE_OFF_FUNC2  6'h0c
`define GPE_OFF_OD     6'h28
`define GPE_OFF_PUP    6'h2c
`define GPE_OFF_PDN    6'h30
`define GPE_OFF_IE     6'h38
`define GPE_OFF_STAT   6'h3c
`define GPE_OFF_MASK   6'h34

// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define GPE_RST_BYTE   8'h00
`define GPE_FUNC2_MASK 8'hd4
`define GPE_PIN_SCLK   2
`define GPE_PIN_EXTERNAL_INTERRUPT_5   4
`define GPE_PIN_EXTERNAL_INTERRUPT_6   6
`define GPE_PIN_EXTERNAL_INTERRUPT_7   7

`endif

// ### verilog/gpe_pkg.sv
/*
 * Types shared by the GPIO port: bus states and peripheral carriers.
 * Assumes peripherals sit on the same clock as the port.
 */
`default_nettype none

package gpe_pkg;

	// Bus slave state: idle or answering
	typedef enum logic [0:0] {
		GPE_BUS_IDLE = 1'b0,
		GPE_BUS_ACK  = 1'b1
	} gpe_bus_e;

	// Signals the peripherals drive toward the pins
	typedef struct packed {
		logic tx;
		logic sclk_out;
		logic sclk_oe;
		logic tmr4_out;
		logic tmr2_out;
		logic tmr3_out;
	} gpe_alt_out_s;

	// Signals the pins deliver to the peripherals
	typedef struct packed {
		logic rx;
		logic sclk_in;
		logic cts;
		logic tmr2_in;
		logic tmr3_in;
	} gpe_alt_in_s;

endpackage

`default_nettype wire

// ### verilog/gpe_port.sv
/*
 * Eight-pin GPIO port with two function-select registers, open-drain,
 * pulls, input gating, external interrupt lines and a change interrupt.
 * Assumes pads resolve pin_out/pin_oe and pulls; stop_mode and
 * drive_stop come from the clock control block on ref_clk.
 */
// Summary of operation
// (R1) Eight pins, each input or output
// (R2) Reset leaves pins plain, everything disabled
// (R3) Both function bits zero means GPIO
// (R4) Software never sets two function bits
// (R5) Selected interrupt survives STOP with drive-off
// (R6) Outside STOP, enabled input reaches interrupts
// (R7) Software disables unused interrupt inputs
// (R8) Data register, low byte, upper zero
// (R9) Output enable bit per pin
// (R10) First function register alternate map
// (R11) Second function register, bits 5,3,1,0 zero
// (R12) Open-drain select per pin
// (R13) Pull-up enable per pin
// (R14) Pull-down register at its offset
// (R15) Input enable register gates input buffer
// (R16) Pull-down bit one enables
// (R17) Input enable bit one enables
`default_nettype none
`include "gpe_regs.svh"

module gpe_port (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic [5:0]            address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [31:0]           writedata,
	input  wire logic [3:0]            byteenable,
	output var  logic [31:0]           readdata,
	output var  logic                  waitrequest,
	input  wire logic [7:0]            pin_in,
	output var  logic [7:0]            pin_out,
	output var  logic [7:0]            pin_oe,
	output var  logic [7:0]            pull_up_en,
	output var  logic [7:0]            pull_dn_en,
	input  wire gpe_pkg::gpe_alt_out_s alt_out,
	output var  gpe_pkg::gpe_alt_in_s  alt_in,
	output var  logic [2:0]            ext_int,
	input  wire logic                  stop_mode,
	input  wire logic                  drive_stop,
	output var  logic                  irq
);
	import gpe_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [7:0]  data_r;      // Output latch
	logic [7:0]  oe_r;        // Output driver enables
	logic [7:0]  func1_r;     // First function select
	logic [7:0]  func2_r;     // Second function select
	logic [7:0]  od_r;        // Open-drain select
	logic [7:0]  pup_r;       // Pull-up enables
	logic [7:0]  pdn_r;       // Pull-down enables
	logic [7:0]  ie_r;        // Input buffer enables
	logic [7:0]  stat_r;      // Sticky change events
	logic [7:0]  mask_r;      // Interrupt mask
	logic [7:0]  sync1_r;     // First synchroniser stage
	logic [7:0]  sync2_r;     // Second synchroniser stage
	logic [7:0]  prev_r;      // Last gated pin level
	logic [7:0]  gated;       // Pin levels behind the input buffer
	logic [7:0]  events;      // Change events this cycle
	logic [7:0]  alt_use;     // Pin driven by a peripheral
	logic [7:0]  alt_val;     // Peripheral drive value
	logic [7:0]  alt_en;      // Drive enable: oe_r, or sclk_oe on pin 2 under SCLK
	logic [7:0]  pin_out_nxt; // Next pad data
	logic [7:0]  pin_oe_nxt;  // Next pad enable
	logic [7:0]  rd_mux;      // Read data before capture
	logic [7:0]  stat_nxt;    // Next status
	logic [7:0]  stat_cap_r;  // Status bits handed to software
	logic [2:0]  int_nxt;     // Next external interrupt lines
	logic        drv_off;     // STOP with pins released
	logic        wr_go;       // Write completes this edge
	logic        rd_stat;     // Status read completes this edge
	gpe_bus_e    bus_r;       // Bus slave state

	// Register hit decode, used by reads and writes alike
	function automatic logic hit(input logic [5:0] a,
		input logic [5:0] off);
		hit = (a == off);
	endfunction

	// ****************************************************************
	// Avalon-MM slave: one wait cycle, then the answer
	// ****************************************************************
	// The answer phase always lasts one cycle, so the master never
	// sees a result built from a half-finished access.
	assign wr_go   = write & (bus_r == GPE_BUS_ACK) & byteenable[0];
	assign rd_stat = read & (bus_r == GPE_BUS_ACK)
		& hit(address, `GPE_OFF_STAT);

	// Handshake state and waitrequest
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bus_r       <= GPE_BUS_IDLE;
			waitrequest <= 1'b1;
		end else if (bus_r == GPE_BUS_IDLE && (read | write)) begin
			bus_r       <= GPE_BUS_ACK;
			waitrequest <= 1'b0;
		end else begin
			// Release after one answer cycle
			bus_r       <= GPE_BUS_IDLE;
			waitrequest <= 1'b1;
		end
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		rd_mux = 8'h00;
		case (address)
			`GPE_OFF_DATA:  rd_mux = (ie_r & sync2_r) | (~ie_r & data_r); // [R8]
			`GPE_OFF_OE:    rd_mux = oe_r;
			`GPE_OFF_FUNC1: rd_mux = func1_r;
			`GPE_OFF_FUNC2: rd_mux = func2_r;
			`GPE_OFF_OD:    rd_mux = od_r;
			`GPE_OFF_PUP:   rd_mux = pup_r;
			`GPE_OFF_PDN:   rd_mux = pdn_r; // [R14]
			`GPE_OFF_IE:    rd_mux = ie_r;
			`GPE_OFF_STAT:  rd_mux = stat_r;
			`GPE_OFF_MASK:  rd_mux = mask_r;
			default:        rd_mux = 8'h00;
		endcase
	end

	// Read data captured in the wait cycle, upper bits zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			readdata   <= 32'h0000_0000;
			stat_cap_r <= `GPE_RST_BYTE;
		end else if (bus_r == GPE_BUS_IDLE && read) begin
			readdata   <= {24'h00_0000, rd_mux}; // [R8]
			stat_cap_r <= hit(address, `GPE_OFF_STAT) ? stat_r : 8'h00;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Everything comes up disabled: plain port, no drive, no pulls
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			data_r  <= `GPE_RST_BYTE; // [R2]
			oe_r    <= `GPE_RST_BYTE; // [R2]
			func1_r <= `GPE_RST_BYTE; // [R2]
			func2_r <= `GPE_RST_BYTE; // [R2]
			od_r    <= `GPE_RST_BYTE;
			pup_r   <= `GPE_RST_BYTE; // [R2]
			pdn_r   <= `GPE_RST_BYTE; // [R2]
			ie_r    <= `GPE_RST_BYTE; // [R2]
			mask_r  <= `GPE_RST_BYTE;
		end else if (wr_go) begin
			// Only the low byte lane carries register bits
			if (hit(address, `GPE_OFF_DATA))
				data_r <= writedata[7:0]; // [R8]
			if (hit(address, `GPE_OFF_OE))
				oe_r <= writedata[7:0]; // [R9] [R1]
			if (hit(address, `GPE_OFF_FUNC1))
				func1_r <= writedata[7:0]; // [R10]
			if (hit(address, `GPE_OFF_FUNC2))
				func2_r <= writedata[7:0] & `GPE_FUNC2_MASK; // [R11]
			if (hit(address, `GPE_OFF_OD))
				od_r <= writedata[7:0]; // [R12]
			if (hit(address, `GPE_OFF_PUP))
				pup_r <= writedata[7:0]; // [R13]
			if (hit(address, `GPE_OFF_PDN))
				pdn_r <= writedata[7:0]; // [R16] [R14]
			if (hit(address, `GPE_OFF_IE))
				ie_r <= writedata[7:0]; // [R17] [R15]
			if (hit(address, `GPE_OFF_MASK))
				mask_r <= writedata[7:0];
		end
	end

	// ****************************************************************
	// Pin input path
	// ****************************************************************
	// Two-stage synchroniser; only the second stage is read
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// Disabled input buffers read low, so floating pins stay quiet
	assign gated   = sync2_r & ie_r; // [R15]
	assign drv_off = stop_mode & drive_stop;

	// ****************************************************************
	// Peripheral routing
	// ****************************************************************
	// Output-type alternates per pin; input-type pins drive the latch under oe_r.
	// Overlapping selects are undefined; here the first function drives the pin and both input functions see its level.
	always_comb begin
		alt_use = 8'h00;
		alt_val = 8'h00;
		alt_en  = oe_r;
		alt_use[0] = func1_r[0]; // [R10]
		alt_val[0] = alt_out.tx;
		alt_use[2] = func1_r[`GPE_PIN_SCLK];
		alt_val[2] = alt_out.sclk_out;
		alt_en[2]  = func1_r[`GPE_PIN_SCLK] ? alt_out.sclk_oe : oe_r[2];
		alt_use[3] = func1_r[3];
		alt_val[3] = alt_out.tmr4_out;
		alt_use[5] = func1_r[5];
		alt_val[5] = alt_out.tmr2_out;
		alt_use[7] = func1_r[7];
		alt_val[7] = alt_out.tmr3_out;
	end

	// Input alternates: selected pin level, else idle zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			alt_in <= '0;
		end else begin
			alt_in.rx      <= func1_r[1] & gated[1]; // [R10]
			alt_in.sclk_in <= func1_r[2] & gated[2];
			alt_in.cts     <= func2_r[2] & gated[2]; // [R11]
			alt_in.tmr2_in <= func1_r[4] & gated[4];
			alt_in.tmr3_in <= func1_r[6] & gated[6];
		end
	end

	// ****************************************************************
	// Pad drive, one slice per pin
	// ****************************************************************
	// Open-drain only pulls low; a high is left to the pull or bus.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pad
			logic val;
			// Both selects zero means the latch drives the pin
			assign val = alt_use[gi] ? alt_val[gi] : data_r[gi]; // [R3]
			assign pin_oe_nxt[gi] = alt_en[gi] & ~drv_off
				& (~od_r[gi] | ~val); // [R12] [R9] [R1]
			assign pin_out_nxt[gi] = od_r[gi] ? 1'b0 : val; // [R12]
		end
	endgenerate

	// Pad outputs and pulls leave through flip-flops
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_out    <= 8'h00;
			pin_oe     <= 8'h00; // [R2]
			pull_up_en <= 8'h00;
			pull_dn_en <= 8'h00;
		end else begin
			pin_out    <= pin_out_nxt;
			pin_oe     <= pin_oe_nxt;
			pull_up_en <= pup_r; // [R13]
			pull_dn_en <= pdn_r; // [R16]
		end
	end

	// ****************************************************************
	// External interrupt lines
	// ****************************************************************
	// Running: enabled input alone passes, whatever the selects say.
	// Stopped with pins released: also needs the interrupt function.
	always_comb begin
		int_nxt[0] = gated[`GPE_PIN_EXTERNAL_INTERRUPT_5]
			& (~drv_off | func2_r[`GPE_PIN_EXTERNAL_INTERRUPT_5]); // [R5] [R6]
		int_nxt[1] = gated[`GPE_PIN_EXTERNAL_INTERRUPT_6]
			& (~drv_off | func2_r[`GPE_PIN_EXTERNAL_INTERRUPT_6]); // [R5] [R6]
		int_nxt[2] = gated[`GPE_PIN_EXTERNAL_INTERRUPT_7]
			& (~drv_off | func2_r[`GPE_PIN_EXTERNAL_INTERRUPT_7]); // [R5] [R6]
	end

	// Registered toward the interrupt controller
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			ext_int <= 3'b000;
		else
			ext_int <= int_nxt;
	end

	// ****************************************************************
	// Change status and interrupt
	// ****************************************************************
	assign events = gated ^ prev_r;

	// Last gated level, for change detection
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			prev_r <= 8'h00;
		else
			prev_r <= gated;
	end

	// A read clears only the bits it returned; new events always set
	assign stat_nxt = (rd_stat ? (stat_r & ~stat_cap_r) : stat_r)
		| events;

	// Sticky status
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			stat_r <= 8'h00;
		else
			stat_r <= stat_nxt;
	end

	// Level interrupt while any unmasked status bit stands
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(stat_nxt & mask_r);
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_reset_quiet: assert property ( // [R2]
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> pin_oe == 8'h00 && ie_r == 8'h00)
		else $error("pins not released after reset");

	a_func2_zeros: assert property ( // [R11]
		@(posedge ref_clk) disable iff (!rst_n)
		(func2_r & ~`GPE_FUNC2_MASK) == 8'h00)
		else $error("reserved select bits set");

	a_data_upper: assert property ( // [R8]
		@(posedge ref_clk) disable iff (!rst_n)
		!waitrequest |-> readdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");

	a_gpio_drive: assert property ( // [R3] [R9]
		@(posedge ref_clk) disable iff (!rst_n)
		(func1_r[0] == 1'b0 && oe_r[0] && !od_r[0] && !drv_off)
		|=> pin_oe[0] && pin_out[0] == $past(data_r[0]))
		else $error("plain pin not driven from latch");

	a_od_high: assert property ( // [R12]
		@(posedge ref_clk) disable iff (!rst_n)
		od_r[1] && !func1_r[1] && data_r[1] |=> !pin_oe[1])
		else $error("open drain drives high");

	a_stop_int: assert property ( // [R5]
		@(posedge ref_clk) disable iff (!rst_n)
		drv_off && !func2_r[7] |=> !ext_int[2])
		else $error("unselected interrupt passed in stop");

	a_run_int: assert property ( // [R6]
		@(posedge ref_clk) disable iff (!rst_n)
		!drv_off && ie_r[6] |=> ext_int[1] == $past(sync2_r[6]))
		else $error("enabled input missed interrupt line");

	a_ie_write: assert property ( // [R17]
		@(posedge ref_clk) disable iff (!rst_n)
		wr_go && hit(address, `GPE_OFF_IE)
		|=> ie_r == $past(writedata[7:0]))
		else $error("input enable write lost");

	a_wait_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(read || write) && waitrequest && bus_r == GPE_BUS_IDLE
		|=> !waitrequest ##1 waitrequest)
		else $error("answer not one cycle after request");

	a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		|(stat_r & mask_r) && !rd_stat |=> irq)
		else $error("pending unmasked event without irq");

endmodule

`default_nettype wire

// ### test/gpe_pad_model.sv
/*
 * Pad and board model seen by the GPIO port pins.
 * Assumes the bench may drive any pin from outside through ext_en.
 */
`default_nettype none

module gpe_pad_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pull_up_en,
	input  wire logic [7:0] pull_dn_en,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	output var  logic [7:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 1ns;

	// A floating pad wanders, so a stale level is never trusted
	logic [7:0] float_r = 8'h55;

	always_ff @(posedge ref_clk) begin
		float_r <= ~float_r;
	end

	// Device drive wins, then board, then pulls
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_lvl[i] = pin_oe[i] ? pin_out[i] :
				ext_en[i] ? ext_val[i] :
				pull_up_en[i] ? 1'b1 :
				pull_dn_en[i] ? 1'b0 : float_r[i];
		end
	end
endmodule

`default_nettype wire

// ### test/tb.sv
/*
 * Self-checking bench of the GPIO port over its Avalon-MM slave.
 * Assumes gpe_port, gpe_pkg and the pad model are compiled first.
 */
`default_nettype none
`include "gpe_regs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import gpe_pkg::*;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic         ref_clk    = 1'b0;
	logic         rst_n      = 1'b0;
	logic [5:0]   address    = 6'h00;
	logic         read       = 1'b0;
	logic         write      = 1'b0;
	logic [31:0]  writedata  = 32'h0;
	logic [3:0]   byteenable = 4'hf;
	gpe_alt_out_s alt_out    = '0;
	logic         stop_mode  = 1'b0;
	logic         drive_stop = 1'b0;
	logic [7:0]   ext_val    = 8'h00;
	logic [7:0]   ext_en     = 8'h00;
	logic [31:0]  readdata;
	logic         waitrequest;
	logic [7:0]   pin_lvl, pin_out, pin_oe, pull_up_en, pull_dn_en;
	gpe_alt_in_s  alt_in;
	logic [2:0]   ext_int;
	logic         irq;
	int           n_fail     = 0;
	int           n_compared = 0;
	int           seed       = 32'habb930e3;
	logic [31:0]  v, r;
	logic [7:0]   b, p, f1;
	// Readback table; index 0 is data, which mixes in pin levels
	logic [5:0]   offs [9] = '{`GPE_OFF_DATA, `GPE_OFF_OE, `GPE_OFF_FUNC1,
		`GPE_OFF_FUNC2, `GPE_OFF_OD, `GPE_OFF_PUP, `GPE_OFF_PDN,
		`GPE_OFF_IE, `GPE_OFF_MASK};

	always #25 ref_clk = ~ref_clk;

	gpe_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .pin_in(pin_lvl), .pin_out(pin_out),
		.pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
		.alt_out(alt_out), .alt_in(alt_in), .ext_int(ext_int),
		.stop_mode(stop_mode), .drive_stop(drive_stop), .irq(irq));

	gpe_pad_model u_pad (.ref_clk(ref_clk), .pin_out(pin_out),
		.pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
		.ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_lvl));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	// Verdict, the single end of the run
	task automatic conclude();
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Case-equality compare, so unknowns never match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus cycle; held until waitrequest is sampled low
	task automatic bus(input logic rd, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		address   <= a;
		writedata <= d;
		read      <= rd;
		write     <= ~rd;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (waitrequest === 1'b0) break;
		end
		// A slave that never answers ends the run
		if (i == 20) begin
			n_fail++;
			conclude();
		end
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b1, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		cyc(3);
		rst_n <= 1'b1;
		cyc(1);
		// Everything comes up cleared and plain
		foreach (offs[k]) rd(offs[k], 32'h0);
		rd(`GPE_OFF_STAT, 32'h0);
		chk({pin_oe, pin_out, pull_up_en, pull_dn_en}, 32'h0);
		// Random readback; second function never overlaps the first
		for (int k = 1; k < 9; k++) begin
			v = $random(seed);
			if (offs[k] == `GPE_OFF_FUNC1) f1 = v[7:0];
			if (offs[k] == `GPE_OFF_OD) p = v[7:0];
			if (offs[k] == `GPE_OFF_FUNC2) v = v & ~{24'h0, f1};
			wr(offs[k], v);
			b = (offs[k] == `GPE_OFF_FUNC2) ? `GPE_FUNC2_MASK : 8'hff;
			rd(offs[k], {24'h0, v[7:0] & b});
		end
		// Disabled byte lane and unmapped place leave no trace
		byteenable <= 4'h0;
		wr(`GPE_OFF_OD, ~v);
		byteenable <= 4'hf;
		rd(`GPE_OFF_OD, {24'h0, p});
		wr(6'h10, 32'hffffffff);
		rd(6'h10, 32'h0);
		foreach (offs[k]) wr(offs[k], 32'h0);
		// Push-pull, open-drain and pulls
		v = $random(seed);
		b = v[7:0];
		wr(`GPE_OFF_DATA, v);
		rd(`GPE_OFF_DATA, {24'h0, b});
		wr(`GPE_OFF_OE, 32'hff);
		p = 8'($random(seed));
		wr(`GPE_OFF_OD, {24'h0, p});
		cyc(2);
		chk({pin_oe, pin_out}, {~(p & b), b & ~p});
		p = 8'($random(seed));
		wr(`GPE_OFF_PUP, {24'h0, p});
		wr(`GPE_OFF_PDN, {24'h0, ~p});
		cyc(2);
		chk({pull_up_en, pull_dn_en}, {p, ~p});
		stop_mode  <= 1'b1;
		drive_stop <= 1'b1;
		cyc(3);
		chk(pin_oe, 32'h0);
		stop_mode  <= 1'b0;
		drive_stop <= 1'b0;
		wr(`GPE_OFF_OE, 32'h0);
		wr(`GPE_OFF_OD, 32'h0);
		// Inputs, change events and the interrupt line
		v = $random(seed);
		ext_en  <= 8'hff;
		ext_val <= v[7:0];
		wr(`GPE_OFF_IE, 32'hff);
		wr(`GPE_OFF_MASK, 32'hff);
		cyc(4);
		bus(1'b1, `GPE_OFF_STAT, 32'h0, r);
		rd(`GPE_OFF_STAT, 32'h0);
		rd(`GPE_OFF_DATA, {24'h0, v[7:0]});
		chk(ext_int, {v[7], v[6], v[4]});
		ext_val <= v[7:0] ^ 8'h81;
		cyc(5);
		chk(irq, 32'h1);
		rd(`GPE_OFF_STAT, 32'h81);
		cyc(2);
		chk(irq, 32'h0);
		// Masked change is recorded but stays quiet
		wr(`GPE_OFF_MASK, 32'h01);
		ext_val <= v[7:0] ^ 8'h01;
		cyc(5);
		chk(irq, 32'h0);
		rd(`GPE_OFF_STAT, 32'h80);
		// Disabled input gates both events and lines
		wr(`GPE_OFF_IE, 32'h0);
		// Dropping the buffer is itself a change; collect it first
		bus(1'b1, `GPE_OFF_STAT, 32'h0, r);
		chk(r, {24'h0, v[7:0] ^ 8'h01});
		ext_val <= ~v[7:0];
		cyc(5);
		rd(`GPE_OFF_STAT, 32'h0);
		chk(ext_int, 32'h0);
		// Only the selected line survives stop with drive off
		wr(`GPE_OFF_IE, 32'hff);
		wr(`GPE_OFF_FUNC2, 32'h80);
		stop_mode  <= 1'b1;
		drive_stop <= 1'b1;
		ext_val    <= v[7:0];
		cyc(5);
		chk(ext_int, {v[7], 2'b00});
		stop_mode  <= 1'b0;
		drive_stop <= 1'b0;
		// Transmit out, receive and clear-to-send in
		wr(`GPE_OFF_FUNC1, 32'h03);
		wr(`GPE_OFF_FUNC2, 32'h04);
		wr(`GPE_OFF_OE, 32'h01);
		ext_en  <= 8'hfe;
		p = 8'($random(seed));
		ext_val <= p;
		v = $random(seed);
		alt_out <= gpe_alt_out_s'({~b[0], v[4:0]});
		cyc(5);
		chk({pin_out[0], alt_in.rx, alt_in.cts}, {~b[0], p[1], p[2]});
		// Both bits clear gives the plain port back
		wr(`GPE_OFF_FUNC1, 32'h0);
		wr(`GPE_OFF_FUNC2, 32'h0);
		cyc(2);
		chk({pin_out[0], alt_in.rx, alt_in.cts}, {b[0], 2'b00});
		// Timer and clock alternates; pins 4 and 6 loop back the latch
		v = $random(seed);
		ext_en  <= 8'h00;
		alt_out <= gpe_alt_out_s'({v[5:4], 1'b1, v[2:0]});
		wr(`GPE_OFF_FUNC1, 32'hfc);
		wr(`GPE_OFF_OE, 32'hff);
		cyc(6);
		r = {26'h1, v[0], b[6], v[1], b[4], v[2], v[4]};
		chk({pin_oe[2], pin_out[7:2]}, r);
		r = {29'h0, v[4], b[4], b[6]};
		chk({alt_in.sclk_in, alt_in.tmr2_in, alt_in.tmr3_in}, r);
		conclude();
	end

	// Hang guard
	initial begin
		cyc(20000);
		n_fail++;
		conclude();
	end
endmodule

`default_nettype wire
